// ### include/spp_consts.vh
`ifndef SPP_CONSTS_VH
`define SPP_CONSTS_VH

// Select mode field encodings
`define SPP_SEL_3WIRE 2'h0
`define SPP_SEL_4W_IN 2'h1

// Control word field positions
`define SPP_CTL_PORT_EN 0
`define SPP_CTL_MASTER_EN 1
`define SPP_CTL_SEL_LO 2
`define SPP_CTL_SEL_HI 3
`define SPP_CTL_W 4

// Control reset value: port off, slave, four-wire input select
`define SPP_CTL_RESET 4'h4
// Select mode after reset: four-wire input
`define SPP_SEL_RESET 2'h1

// Bits per transfer and last bit index
`define SPP_BITS 8
`define SPP_LAST_BIT 3'h7

// Master serial clock: system clocks per half period
`define SPP_HALF_DIV 4

// Far master must lower select this many system clocks before first edge
`define SPP_SEL_SETUP_CLK 2

// Data and counter reset values
`define SPP_BYTE_RESET 8'h00
`define SPP_CNT_RESET 3'h0

`endif

// ### hdl/spp_sync.v
// Two flip-flop synchroniser for pin inputs
module spp_sync #(
  parameter W = 4,
  // Reset level per bit, the idle level of each pin
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock, reset, enable
  input wire mclk,
  input wire rst_b,
  input wire ce,
  // Asynchronous inputs
  input wire [W-1:0] async_in,
  // Synchronised outputs
  output reg [W-1:0] sync_out
);

  // First stage, read only by the second
  reg [W-1:0] meta_r;

  // Two stages, both frozen while ce is low
  always @(posedge mclk) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (ce) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ### hdl/spp_sckdiv.v
// Half period tick generator for the master serial clock
module spp_sckdiv #(
  parameter HALF_DIV = 4
) (
  // Clock, reset, enable
  input wire mclk,
  input wire rst_b,
  input wire ce,
  // Run request from the port
  input wire run,
  // One cycle pulse at each half period
  output wire tick
);

  // Counter of system clocks within a half period
  reg [15:0] cnt_r;
  reg [15:0] cnt_nxt;

  // Last count of a half period, cut to the counter width on purpose
  localparam integer LAST_I = HALF_DIV - 1;
  localparam [15:0] LAST = LAST_I[15:0];

  assign tick = run && (cnt_r == LAST);

  // Next count: restart when idle or at the end of a half period
  always @* begin
    if (!run || cnt_r == LAST) begin
      cnt_nxt = 16'h0000;
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  // Count register
  always @(posedge mclk) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ### hdl/spp_top.v
`include "spp_consts.vh"

module spp_top #(
  parameter NPORT = 2,
  parameter HALF_DIV = `SPP_HALF_DIV
) (
  // Clock, reset, enable
  input wire mclk,
  input wire rst_b,
  input wire ce,
  // Control writes, one word per port
  input wire [NPORT-1:0] ctl_wr,
  input wire [NPORT*`SPP_CTL_W-1:0] ctl_wdata,
  output wire [NPORT*`SPP_CTL_W-1:0] ctl_rdata,
  // Flag clears, one pulse per port
  input wire [NPORT-1:0] done_clr,
  input wire [NPORT-1:0] fault_clr,
  // Status flags
  output wire [NPORT-1:0] done_flag,
  output wire [NPORT-1:0] mode_fault_flag,
  // Transmit byte path
  input wire [NPORT-1:0] tx_wr,
  input wire [NPORT*8-1:0] tx_data,
  output wire [NPORT-1:0] tx_full,
  // Received byte
  output wire [NPORT*8-1:0] rx_data,
  // Master-out slave-in pin
  input wire [NPORT-1:0] mosi_i,
  output wire [NPORT-1:0] mosi_o,
  output wire [NPORT-1:0] mosi_oe,
  // Master-in slave-out pin
  input wire [NPORT-1:0] miso_i,
  output wire [NPORT-1:0] miso_o,
  output wire [NPORT-1:0] miso_oe,
  // Serial clock pin
  input wire [NPORT-1:0] sck_i,
  output wire [NPORT-1:0] sck_o,
  output wire [NPORT-1:0] sck_oe,
  // Select pin and its crossbar mapping
  input wire [NPORT-1:0] nss_i,
  output wire [NPORT-1:0] nss_o,
  output wire [NPORT-1:0] nss_oe,
  output wire [NPORT-1:0] nss_mapped
);

  // Slave is selected unless in four-wire input mode with a high select input
  function sel_active;
    input [1:0] mode;
    input nss_lvl;
    begin
      if (mode == `SPP_SEL_3WIRE) begin
        sel_active = 1'b1;
      end else if (mode == `SPP_SEL_4W_IN) begin
        sel_active = !nss_lvl;
      end else begin
        sel_active = 1'b1;
      end
    end
  endfunction

  genvar gi;

  // Each instance is a complete, independent port
  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port

      // Control state; a fault clears both enables but keeps the select mode
      reg port_en_r;
      reg master_en_r;
      reg [1:0] sel_mode_r;
      // Flags
      reg done_r;
      reg fault_r;
      // Data path
      reg [7:0] tx_buf_r;
      reg tx_full_r;
      reg [7:0] shift_r;
      reg shift_empty_r;
      reg [7:0] rx_r;
      reg [2:0] bit_cnt_r;
      reg in_bit_r;
      // Master clock generation
      reg run_r;
      reg sck_r;
      // Previous synchronised levels for edge detection
      reg sck_d_r;
      reg nss_d_r;

      // Synchronised pins: select, clock, data-out, data-in
      wire [3:0] pin_s;
      wire nss_s = pin_s[3];
      wire sck_s = pin_s[2];
      wire mosi_s = pin_s[1];
      wire miso_s = pin_s[0];
      wire tick;

      // Pins pass two flops before any edge or select logic
      // Select idles high: its stages reset high, so no false fall
      spp_sync #(
        .W(4),
        .RST_VAL(4'h8)
      ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .async_in({nss_i[gi], sck_i[gi], mosi_i[gi], miso_i[gi]}),
        .sync_out(pin_s)
      );

      // Half period ticks while a master transfer runs
      spp_sckdiv #(
        .HALF_DIV(HALF_DIV)
      ) u_div (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .run(run_r),
        .tick(tick)
      );

      // Role decode
      wire is_master = port_en_r && master_en_r;
      wire is_slave = port_en_r && !master_en_r;
      wire sel_now = sel_active(sel_mode_r, nss_s);
      wire slave_sel = is_slave && sel_now;
      wire nss_fall = nss_d_r && !nss_s;
      // Select fall in multi-master mode is a fault
      wire fault_ev = is_master && (sel_mode_r == `SPP_SEL_4W_IN) && nss_fall;
      // Slave bit counter restarts on select fall
      wire cnt_clr = is_slave && (sel_mode_r == `SPP_SEL_4W_IN) && nss_fall;

      // Shift events: master from divider, slave from pin edges when selected
      wire m_rise = run_r && tick && !sck_r;
      wire m_fall = run_r && tick && sck_r;
      wire s_rise = slave_sel && !sck_d_r && sck_s;
      wire s_fall = slave_sel && sck_d_r && !sck_s;
      wire rise_ev = m_rise || s_rise;
      wire fall_ev = m_fall || s_fall;
      // Sample master side from data-in, slave side from data-out
      wire samp_bit = is_master ? miso_s : mosi_s;
      wire last_fall = fall_ev && (bit_cnt_r == `SPP_LAST_BIT);
      wire rx_byte_ok = last_fall && !fault_ev;
      // Shift register may take the buffer when empty
      wire load_ok = tx_full_r && shift_empty_r && port_en_r && !run_r;

      // Edge history of synchronised pins
      always @(posedge mclk) begin
        if (!rst_b) begin
          sck_d_r <= 1'b0;
          nss_d_r <= 1'b1;
        end else if (ce) begin
          sck_d_r <= sck_s;
          nss_d_r <= nss_s;
        end
      end

      // Control word; a fault clears both enables and beats a write
      always @(posedge mclk) begin
        if (!rst_b) begin
          port_en_r <= 1'b0;
          master_en_r <= 1'b0;
          sel_mode_r <= `SPP_SEL_RESET;
        end else if (ce) begin
          if (fault_ev) begin
            port_en_r <= 1'b0;
            master_en_r <= 1'b0;
          end else if (ctl_wr[gi]) begin
            port_en_r <= ctl_wdata[gi*`SPP_CTL_W+`SPP_CTL_PORT_EN];
            master_en_r <= ctl_wdata[gi*`SPP_CTL_W+`SPP_CTL_MASTER_EN];
            sel_mode_r <= ctl_wdata[gi*`SPP_CTL_W+`SPP_CTL_SEL_LO +: 2];
          end
        end
      end

      // Sticky flags; a set in the clear cycle wins
      always @(posedge mclk) begin
        if (!rst_b) begin
          done_r <= 1'b0;
          fault_r <= 1'b0;
        end else if (ce) begin
          if (rx_byte_ok) begin
            done_r <= 1'b1;
          end else if (done_clr[gi]) begin
            done_r <= 1'b0;
          end
          if (fault_ev) begin
            fault_r <= 1'b1;
          end else if (fault_clr[gi]) begin
            fault_r <= 1'b0;
          end
        end
      end

      // Transmit buffer; a write while full is dropped
      always @(posedge mclk) begin
        if (!rst_b) begin
          tx_buf_r <= `SPP_BYTE_RESET;
          tx_full_r <= 1'b0;
        end else if (ce) begin
          if (load_ok) begin
            tx_full_r <= 1'b0;
          end else if (tx_wr[gi] && !tx_full_r) begin
            tx_buf_r <= tx_data[gi*8 +: 8];
            tx_full_r <= 1'b1;
          end
        end
      end

      // Master run control and generated serial clock
      always @(posedge mclk) begin
        if (!rst_b) begin
          run_r <= 1'b0;
          sck_r <= 1'b0;
        end else if (ce) begin
          if (!is_master || fault_ev) begin
            // Abort leaves the clock low for the next master
            run_r <= 1'b0;
            sck_r <= 1'b0;
          end else if (load_ok) begin
            run_r <= 1'b1;
          end else if (m_rise) begin
            sck_r <= 1'b1;
          end else if (m_fall) begin
            sck_r <= 1'b0;
            if (bit_cnt_r == `SPP_LAST_BIT) begin
              run_r <= 1'b0;
            end
          end
        end
      end

      // Shift register: sample on rise, shift toward MSB on fall
      always @(posedge mclk) begin
        if (!rst_b) begin
          shift_r <= `SPP_BYTE_RESET;
          shift_empty_r <= 1'b1;
          in_bit_r <= 1'b0;
          bit_cnt_r <= `SPP_CNT_RESET;
          rx_r <= `SPP_BYTE_RESET;
        end else if (ce) begin
          if (!port_en_r || cnt_clr) begin
            // Disable or select fall restarts the byte
            bit_cnt_r <= `SPP_CNT_RESET;
            shift_empty_r <= !port_en_r ? 1'b1 : shift_empty_r;
          end else if (load_ok) begin
            shift_r <= tx_buf_r;
            shift_empty_r <= 1'b0;
          end else if (rise_ev) begin
            in_bit_r <= samp_bit;
          end else if (fall_ev) begin
            shift_r <= {shift_r[6:0], in_bit_r};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == `SPP_LAST_BIT) begin
              rx_r <= {shift_r[6:0], in_bit_r};
              shift_empty_r <= 1'b1;
            end
          end
        end
      end

      // Pin drive
      assign mosi_o[gi] = shift_r[7];
      assign mosi_oe[gi] = is_master;
      assign miso_o[gi] = shift_r[7];
      // Released when disabled, master, or an unselected four-wire slave
      assign miso_oe[gi] = slave_sel;
      assign sck_o[gi] = sck_r;
      assign sck_oe[gi] = is_master;
      assign nss_o[gi] = sel_mode_r[0];
      assign nss_oe[gi] = sel_mode_r[1];
      assign nss_mapped[gi] = (sel_mode_r != `SPP_SEL_3WIRE);

      // Status and readback
      assign ctl_rdata[gi*`SPP_CTL_W +: `SPP_CTL_W] =
        {sel_mode_r, master_en_r, port_en_r};
      assign done_flag[gi] = done_r;
      assign mode_fault_flag[gi] = fault_r;
      assign tx_full[gi] = tx_full_r;
      assign rx_data[gi*8 +: 8] = rx_r;
    end
  endgenerate

endmodule

// ### bench/spp_top_props.sv
// Pin direction and select checks, port 0 as master, port 1 as slave
module spp_top_props #(
  parameter NPORT = 2
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Control readback and fault
  input wire [NPORT*4-1:0] ctl_rdata,
  input wire [NPORT-1:0] mode_fault_flag,
  // Pin drive
  input wire [NPORT-1:0] mosi_oe,
  input wire [NPORT-1:0] miso_oe,
  input wire [NPORT-1:0] sck_oe,
  input wire [NPORT-1:0] nss_i,
  input wire [NPORT-1:0] nss_o,
  input wire [NPORT-1:0] nss_oe,
  input wire [NPORT-1:0] nss_mapped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Control words of each port
  wire [3:0] c0 = ctl_rdata[3:0];
  wire [3:0] c1 = ctl_rdata[7:4];
  property p_mosi_dir; mosi_oe[0] == (c0[0] & c0[1]); endproperty
  a_mosi_dir: assert property (p_mosi_dir) else $error("mosi drive wrong");
  property p_miso_mst; c0[1] |-> !miso_oe[0]; endproperty
  a_miso_mst: assert property (p_miso_mst) else $error("master drives miso");
  property p_miso_off; !c1[0] |-> !miso_oe[1]; endproperty
  a_miso_off: assert property (p_miso_off) else $error("disabled drives miso");
  property p_miso_3w; c1 == 4'h1 |-> miso_oe[1]; endproperty
  a_miso_3w: assert property (p_miso_3w) else $error("3w slave idle");
  // Sync delay: select must stay high a few cycles first
  property p_unsel; (c1 == 4'h5 && nss_i[1]) [*5] |-> !miso_oe[1]; endproperty
  a_unsel: assert property (p_unsel) else $error("unselected drives");
  property p_sck_dir; !(c0[0] & c0[1]) |-> !sck_oe[0]; endproperty
  a_sck_dir: assert property (p_sck_dir) else $error("slave drives sck");
  property p_nss_out; nss_oe[0] == c0[3] && nss_o[0] == c0[2]; endproperty
  a_nss_out: assert property (p_nss_out) else $error("select out wrong");
  property p_mapped; nss_mapped[0] == (c0[3:2] != 2'h0); endproperty
  a_mapped: assert property (p_mapped) else $error("select mapping wrong");
  property p_fault; c0 == 4'h7 && $fell(nss_i[0]) |-> ##[2:6] mode_fault_flag[0]; endproperty
  a_fault: assert property (p_fault) else $error("no mode fault");
  property p_fclr; $rose(mode_fault_flag[0]) |-> ##[0:1] c0[1:0] == 2'h0; endproperty
  a_fclr: assert property (p_fclr) else $error("enables kept on fault");
endmodule
bind spp_top spp_top_props #(.NPORT(NPORT)) i_spp_top_props (.mclk(mclk), .rst_b(rst_b),
  .ctl_rdata(ctl_rdata), .mode_fault_flag(mode_fault_flag), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .sck_oe(sck_oe), .nss_i(nss_i), .nss_o(nss_o), .nss_oe(nss_oe),
  .nss_mapped(nss_mapped));

// ### bench/spp_slave_model.sv
// Far slave, clock idle low, sample on rise, shift on fall
module spp_slave_model (
  // Serial pins
  input wire sck,
  input wire mosi,
  input wire en,
  // Byte out, byte in
  input wire [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  initial rx = 8'h00;
  // Selected: first bit ready before first rise
  always @(posedge en) begin
    sh = tx;
    miso = tx[7];
  end
  // Released: flip so a stale level is never read as data
  always @(negedge en) miso = ~miso;
  always @(posedge sck) if (en) rx = {rx[6:0], mosi};
  always @(negedge sck) if (en) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule

// ### bench/tb_spp_top.sv
`define CHK(n, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end \
end
module tb_spp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_b, mosi1, sck1;
  logic [1:0] ctl_wr, done_clr, fault_clr, tx_wr, nss_i;
  logic [7:0] ctl_wdata;
  logic [15:0] tx_data;
  wire [7:0] ctl_rdata, s_rx;
  wire [15:0] rx_data;
  wire [1:0] done_flag, mode_fault_flag, tx_full, mosi_o, mosi_oe, miso_o, miso_oe;
  wire [1:0] sck_o, sck_oe, nss_o, nss_oe, nss_mapped;
  wire p_miso;
  int failures = 0;
  int samples_checked = 0;
  spp_top i_spp_top (.mclk(mclk), .rst_b(rst_b), .ce(1'b1), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .done_clr(done_clr), .fault_clr(fault_clr),
    .done_flag(done_flag), .mode_fault_flag(mode_fault_flag), .tx_wr(tx_wr), .tx_data(tx_data),
    .tx_full(tx_full), .rx_data(rx_data), .mosi_i({mosi1, 1'b0}), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i({1'b0, p_miso}), .miso_o(miso_o), .miso_oe(miso_oe),
    .sck_i({sck1, 1'b0}), .sck_o(sck_o), .sck_oe(sck_oe), .nss_i(nss_i), .nss_o(nss_o),
    .nss_oe(nss_oe), .nss_mapped(nss_mapped));
  spp_slave_model i_spp_slave_model (.sck(sck_o[0]), .mosi(mosi_o[0]),
    .en(nss_oe[0] & ~nss_o[0]), .tx(8'h3c), .miso(p_miso), .rx(s_rx));
  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_ctl(int p, logic [3:0] v);
    ctl_wdata[p*4 +: 4] = v;
    ctl_wr[p] = 1;
    tick();
    ctl_wr[p] = 0;
    tick();
  endtask
  task automatic wr_tx(int p, logic [7:0] v);
    tx_data[p*8 +: 8] = v;
    tx_wr[p] = 1;
    tick();
    tx_wr[p] = 0;
    tick();
  endtask
  // Bounded wait on done (f=0) or fault (f=1)
  task automatic wait_flag(int p, bit f);
    int k;
    for (k = 0; k < 400; k++) begin
      if ((f ? mode_fault_flag[p] : done_flag[p]) === 1'b1) break;
      tick();
    end
    if (k == 400) begin
      failures++;
      wrap_up();
    end
  endtask
  // First n bits of a byte from the far master, 125 ns link period
  task automatic sbyte(logic [7:0] b, int n, output logic [7:0] got);
    for (int i = 7; i > 7 - n; i--) begin
      mosi1 = b[i];
      tick(12);
      got[i] = miso_o[1];
      sck1 = 1;
      tick(13);
      sck1 = 0;
    end
    tick(12);
  endtask
  task automatic t_master;
    wr_ctl(0, 4'hb);
    `CHK("nss_oe", 1'b1, nss_oe[0])
    `CHK("nss_o", 1'b0, nss_o[0])
    `CHK("mosi_oe", 1'b1, mosi_oe[0])
    wr_tx(0, 8'ha5);
    wait_flag(0, 0);
    tick(2);
    `CHK("m_rx", 8'h3c, rx_data[7:0])
    `CHK("far_rx", 8'ha5, s_rx)
    $display("t_master done");
  endtask
  task automatic t_slave;
    logic [7:0] got;
    wr_ctl(1, 4'h5);
    wr_tx(1, 8'hc3);
    wr_tx(1, 8'h5a);
    `CHK("tx_full", 1'b1, tx_full[1])
    `CHK("oe_unsel", 1'b0, miso_oe[1])
    sbyte(8'hff, 8, got);
    `CHK("ignored", 1'b0, done_flag[1])
    nss_i[1] = 0;
    tick(4);
    `CHK("oe_sel", 1'b1, miso_oe[1])
    sbyte(8'h96, 8, got);
    tick(4);
    `CHK("s_out", 8'hc3, got)
    `CHK("s_rx", 8'h96, rx_data[15:8])
    `CHK("s_done", 1'b1, done_flag[1])
    `CHK("tx_moved", 1'b0, tx_full[1])
    // Cut a byte short, then reselect: the bit count must restart
    done_clr[1] = 1;
    tick();
    done_clr[1] = 0;
    sbyte(8'hff, 3, got);
    nss_i[1] = 1;
    tick(4);
    nss_i[1] = 0;
    tick(4);
    `CHK("cut_done", 1'b0, done_flag[1])
    sbyte(8'ha9, 8, got);
    tick(4);
    `CHK("cut_rx", 8'ha9, rx_data[15:8])
    `CHK("cut_done2", 1'b1, done_flag[1])
    nss_i[1] = 1;
    wr_ctl(1, 4'h1);
    `CHK("oe_3w", 1'b1, miso_oe[1])
    `CHK("miso_3w", 1'b1, miso_o[1])
    `CHK("map_3w", 1'b0, nss_mapped[1])
    $display("t_slave done");
  endtask
  task automatic t_fault;
    wr_ctl(0, 4'h7);
    nss_i[0] = 0;
    wait_flag(0, 1);
    tick();
    `CHK("ctl_fault", 4'h4, ctl_rdata[3:0])
    fault_clr[0] = 1;
    tick();
    fault_clr[0] = 0;
    tick();
    `CHK("fault_clr", 1'b0, mode_fault_flag[0])
    $display("t_fault done");
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {rst_b, mosi1, sck1, ctl_wr, done_clr, fault_clr, tx_wr} = '0;
    nss_i = 2'h3;
    ctl_wdata = 8'h00;
    tx_data = 16'h0000;
    repeat (20) @(posedge mclk);
    #1 rst_b = 1;
    tick();
    `CHK("ctl_rst", 8'h44, ctl_rdata)
    `CHK("oe_rst", 2'h0, miso_oe | mosi_oe | nss_oe)
    t_master();
    t_slave();
    t_fault();
    wrap_up();
  end
endmodule
